// ### verilog/spf_fwd_ctrl.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps

// Behaviour
// [RULE1] Enable bit 7 forwards unknown-destination frames to the low three-bit port mask.
// [RULE2] Mask bit 2 is port 3, bit 0 port 1; resets to all ones.
// [RULE3] Bits 7..3 hold port 1 transceiver address; 0, 30, 31 unusable; reset 1.
// [RULE4] Port 2 transceiver address is port 1 plus one; low bits read-only zero.
// [RULE5] Three identical port control registers at 0x10, 0x20, 0x30.
// [RULE6] Bit 7 enables broadcast storm protection on received frames.
// [RULE7] Bit 6 enables DiffServ priority classification of IP frames.
// [RULE8] Bit 5 enables 802.1p tag priority classification.
// [RULE9] Bits 4..3 give default queue when other classifiers are off or miss.
// [RULE10] 802.1p and DiffServ results are OR'ed and override port priority.
// [RULE11] Tag insertion bit clear means no tag inserted on egress.
// [RULE12] Insertion bit set tags untagged frames with the port default tag.
// [RULE13] Removal bit strips tags from tagged frames; untagged frames pass unchanged.
// [RULE14] Bit 0 selects four output queues; clear means single queue, priority ignored.
// [RULE15] Software leaves reserved bits 6..3 of unknown-destination register at zero.
// [RULE16] Each of eight tag priorities maps through a programmable two-bit field.
module spf_fwd_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frm_valid,
	input wire logic [1:0] frm_rx_port,
	input wire logic [1:0] frm_tx_port,
	input wire logic frm_tagged,
	input wire logic [2:0] frm_pcp,
	input wire logic frm_ip,
	input wire logic frm_dscp_hit,
	input wire logic [1:0] frm_dscp_prio,
	input wire logic frm_broadcast,
	input wire logic frm_dest_unknown,
	output logic dec_valid,
	output logic [1:0] dec_class_prio,
	output logic [1:0] dec_queue,
	output logic [2:0] dec_unknown_mask,
	output logic dec_storm_check,
	output logic dec_tag_insert,
	output logic dec_tag_strip,
	output logic [4:0] phy1_addr,
	output logic [4:0] phy2_addr
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic aw_rdy;
		logic aw_full;
		logic [5:0] aw_idx;
		logic w_rdy;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] map_lo;
		logic [7:0] map_hi;
		logic [7:0] unk_fwd;
		logic [7:0] xcvr;
		logic [2:0][7:0] pctl;
		logic dec_valid;
		logic [1:0] class_prio;
		logic [1:0] queue;
		logic [2:0] unk_mask;
		logic storm;
		logic tag_ins;
		logic tag_strip;
		logic [4:0] phy1;
		logic [4:0] phy2;
	} spf_state_t;

	spf_state_t st_r;
	spf_state_t st_nxt;
	logic [1:0] rst_sync_r;
	logic rst_sync_b;

	// ****************************************
	// Helpers
	// ****************************************
	// Port numbers 1..3; code 0 selects nothing, so all features read as off
	function automatic logic [7:0] port_ctrl(input logic [1:0] port, input spf_state_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (port)
			2'h1: v = s.pctl[0];
			2'h2: v = s.pctl[1];
			2'h3: v = s.pctl[2];
			2'h0: v = 8'h00;
		endcase
		return v;
	endfunction

	function automatic logic [5:0] word_idx(input logic [ADDR_W-1:0] a);
		return a[7:2];
	endfunction

	function automatic logic idx_mapped(input logic [5:0] idx);
		return idx == spf_pkg::IDX_PRIO_MAP_LO || idx == spf_pkg::IDX_PRIO_MAP_HI ||
			idx == spf_pkg::IDX_UNK_FWD || idx == spf_pkg::IDX_XCVR ||
			idx == spf_pkg::IDX_PORT1 || idx == spf_pkg::IDX_PORT2 ||
			idx == spf_pkg::IDX_PORT3;
	endfunction

	function automatic logic [7:0] reg_read(input logic [5:0] idx, input spf_state_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			spf_pkg::IDX_PRIO_MAP_LO: v = s.map_lo;
			spf_pkg::IDX_PRIO_MAP_HI: v = s.map_hi;
			spf_pkg::IDX_UNK_FWD: v = s.unk_fwd;
			spf_pkg::IDX_XCVR: v = s.xcvr;
			spf_pkg::IDX_PORT1: v = s.pctl[0];
			spf_pkg::IDX_PORT2: v = s.pctl[1];
			spf_pkg::IDX_PORT3: v = s.pctl[2];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ****************************************
	// Reset release
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_sync_r[1];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [7:0] rx_ctl;
		logic [7:0] tx_ctl;
		logic [15:0] map;
		logic [1:0] pcp_prio;
		logic [1:0] ds_prio;
		logic hit;
		logic [4:0] new_addr;
		rx_ctl = 8'h00;
		tx_ctl = 8'h00;
		map = 16'h0000;
		pcp_prio = 2'h0;
		ds_prio = 2'h0;
		hit = 1'b0;
		new_addr = 5'h00;
		st_nxt = st_r;

		// Write channel: address and data taken in either order
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (s_axi_awvalid && st_r.aw_rdy) begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_idx = word_idx(s_axi_awaddr);
		end
		if (s_axi_wvalid && st_r.w_rdy) begin
			st_nxt.w_full = 1'b1;
			st_nxt.w_data = s_axi_wdata[7:0];
			st_nxt.w_lane0 = s_axi_wstrb[0];
		end
		if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = idx_mapped(st_r.aw_idx) ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
			if (st_r.w_lane0) begin
				new_addr = st_r.w_data[7:spf_pkg::XCVR_ADDR_LSB];
				unique case (st_r.aw_idx)
					spf_pkg::IDX_PRIO_MAP_LO: st_nxt.map_lo = st_r.w_data; // [RULE16]
					spf_pkg::IDX_PRIO_MAP_HI: st_nxt.map_hi = st_r.w_data; // [RULE16]
					spf_pkg::IDX_UNK_FWD: st_nxt.unk_fwd = st_r.w_data; // [RULE1] [RULE2]
					spf_pkg::IDX_XCVR: begin
						// Unusable codes are dropped so a port 2 address never wraps
						if (new_addr != spf_pkg::XCVR_NA_ZERO &&
							new_addr != spf_pkg::XCVR_NA_HI0 &&
							new_addr != spf_pkg::XCVR_NA_HI1) begin
							st_nxt.xcvr = {new_addr, 3'h0}; // [RULE3] [RULE4]
						end
					end
					spf_pkg::IDX_PORT1: st_nxt.pctl[0] = st_r.w_data; // [RULE5]
					spf_pkg::IDX_PORT2: st_nxt.pctl[1] = st_r.w_data; // [RULE5]
					spf_pkg::IDX_PORT3: st_nxt.pctl[2] = st_r.w_data; // [RULE5]
					default: st_nxt.bresp = spf_pkg::RESP_SLVERR;
				endcase
			end
		end
		st_nxt.aw_rdy = !st_nxt.aw_full && !st_nxt.bvalid;
		st_nxt.w_rdy = !st_nxt.w_full && !st_nxt.bvalid;

		// Read channel: one beat, answer on the cycle after the address
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_r.ar_rdy) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {24'h000000, reg_read(word_idx(s_axi_araddr), st_r)};
			st_nxt.rresp = idx_mapped(word_idx(s_axi_araddr)) ? spf_pkg::RESP_OKAY :
				spf_pkg::RESP_SLVERR;
		end
		st_nxt.ar_rdy = !st_nxt.rvalid;

		// Transceiver management addresses
		st_nxt.phy1 = st_r.xcvr[7:spf_pkg::XCVR_ADDR_LSB]; // [RULE3]
		st_nxt.phy2 = 5'(st_r.xcvr[7:spf_pkg::XCVR_ADDR_LSB] + 5'h01); // [RULE4]

		// Frame decision, one cycle after the frame descriptor
		rx_ctl = port_ctrl(frm_rx_port, st_r);
		tx_ctl = port_ctrl(frm_tx_port, st_r);
		map = {st_r.map_hi, st_r.map_lo};
		pcp_prio = 2'(map >> {frm_pcp, 1'b0}); // [RULE16]
		if (rx_ctl[spf_pkg::PC_PCP_BIT] && frm_tagged) begin
			hit = 1'b1; // [RULE8]
		end else begin
			pcp_prio = 2'h0;
		end
		if (rx_ctl[spf_pkg::PC_DSCP_BIT] && frm_ip && frm_dscp_hit) begin
			hit = 1'b1; // [RULE7]
			ds_prio = frm_dscp_prio;
		end
		st_nxt.dec_valid = frm_valid;
		if (hit) begin
			st_nxt.class_prio = pcp_prio | ds_prio; // [RULE10]
		end else begin
			st_nxt.class_prio = rx_ctl[spf_pkg::PC_PRIO_LSB +: 2]; // [RULE9]
		end
		// Single queue ignores priority entirely
		st_nxt.queue = tx_ctl[spf_pkg::PC_MULTIQ_BIT] ? st_nxt.class_prio : 2'h0; // [RULE14]
		st_nxt.storm = rx_ctl[spf_pkg::PC_STORM_BIT] && frm_broadcast; // [RULE6]
		st_nxt.tag_ins = tx_ctl[spf_pkg::PC_INSERT_BIT] && !frm_tagged; // [RULE11] [RULE12]
		st_nxt.tag_strip = tx_ctl[spf_pkg::PC_STRIP_BIT] && frm_tagged; // [RULE13]
		if (frm_dest_unknown && st_r.unk_fwd[spf_pkg::UNK_EN_BIT]) begin
			st_nxt.unk_mask = st_r.unk_fwd[spf_pkg::UNK_MASK_LSB +: 3]; // [RULE1] [RULE2]
		end else begin
			st_nxt.unk_mask = 3'h0;
		end
		if (!frm_valid) begin
			st_nxt.class_prio = 2'h0;
			st_nxt.queue = 2'h0;
			st_nxt.storm = 1'b0;
			st_nxt.tag_ins = 1'b0;
			st_nxt.tag_strip = 1'b0;
			st_nxt.unk_mask = 3'h0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_r <= '0;
			st_r.map_lo <= spf_pkg::RST_PRIO_MAP_LO;
			st_r.map_hi <= spf_pkg::RST_PRIO_MAP_HI;
			st_r.unk_fwd <= spf_pkg::RST_UNK_FWD; // [RULE2] [RULE15]
			st_r.xcvr <= spf_pkg::RST_XCVR; // [RULE3]
			st_r.pctl <= {3{spf_pkg::RST_PORT_CTRL}}; // [RULE6] [RULE11]
			st_r.phy1 <= spf_pkg::RST_XCVR[7:3];
			st_r.phy2 <= 5'(spf_pkg::RST_XCVR[7:3] + 5'h01);
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready = st_r.aw_rdy;
	assign s_axi_wready = st_r.w_rdy;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.ar_rdy;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = st_r.rdata;
	assign dec_valid = st_r.dec_valid;
	assign dec_class_prio = st_r.class_prio;
	assign dec_queue = st_r.queue;
	assign dec_unknown_mask = st_r.unk_mask;
	assign dec_storm_check = st_r.storm;
	assign dec_tag_insert = st_r.tag_ins;
	assign dec_tag_strip = st_r.tag_strip;
	assign phy1_addr = st_r.phy1;
	assign phy2_addr = st_r.phy2;

endmodule

// ### verilog/spf_pkg.sv
package spf_pkg;

	// ****************************************
	// Register indices (byte address = 4 x index)
	// ****************************************
	localparam int IDX_W = 6;
	localparam logic [5:0] IDX_PRIO_MAP_LO = 6'h0C;
	localparam logic [5:0] IDX_PRIO_MAP_HI = 6'h0D;
	localparam logic [5:0] IDX_UNK_FWD = 6'h0E;
	localparam logic [5:0] IDX_XCVR = 6'h0F;
	localparam logic [5:0] IDX_PORT1 = 6'h10;
	localparam logic [5:0] IDX_PORT2 = 6'h20;
	localparam logic [5:0] IDX_PORT3 = 6'h30;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_PRIO_MAP_LO = 8'h50;
	localparam logic [7:0] RST_PRIO_MAP_HI = 8'hFA;
	localparam logic [7:0] RST_UNK_FWD = 8'h07;
	localparam logic [7:0] RST_XCVR = 8'h08;
	localparam logic [7:0] RST_PORT_CTRL = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int UNK_EN_BIT = 7;
	localparam int UNK_MASK_LSB = 0;
	localparam int XCVR_ADDR_LSB = 3;
	localparam logic [2:0] XCVR_RO_MASK = 3'h7;
	localparam int PC_STORM_BIT = 7;
	localparam int PC_DSCP_BIT = 6;
	localparam int PC_PCP_BIT = 5;
	localparam int PC_PRIO_LSB = 3;
	localparam int PC_INSERT_BIT = 2;
	localparam int PC_STRIP_BIT = 1;
	localparam int PC_MULTIQ_BIT = 0;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [4:0] XCVR_NA_ZERO = 5'h00;
	localparam logic [4:0] XCVR_NA_HI0 = 5'h1E;
	localparam logic [4:0] XCVR_NA_HI1 = 5'h1F;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verification/spf_fwd_ctrl_checker.sv
`timescale 1ns/100ps
module spf_fwd_ctrl_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic frm_valid,
	input wire logic frm_tagged,
	input wire logic frm_broadcast,
	input wire logic frm_dest_unknown,
	input wire logic dec_valid,
	input wire logic [1:0] dec_class_prio,
	input wire logic [1:0] dec_queue,
	input wire logic [2:0] dec_unknown_mask,
	input wire logic dec_storm_check,
	input wire logic dec_tag_insert,
	input wire logic dec_tag_strip,
	input wire logic [4:0] phy1_addr,
	input wire logic [4:0] phy2_addr
);
	// ************
	// Properties
	// ************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_dec_one_cycle: assert property (dec_valid == $past(frm_valid))
		else $error("decision not one cycle after frame");
	a_unk_mask_gate: assert property (dec_unknown_mask != 3'h0 |-> $past(frm_dest_unknown))
		else $error("mask without unknown destination");
	a_phy_code_legal: assert property (!(phy1_addr inside {5'h00, 5'h1E, 5'h1F}))
		else $error("illegal transceiver address");
	a_phy2_plus_one: assert property (phy2_addr == phy1_addr + 5'h01)
		else $error("second address not first plus one");
	a_storm_bcast: assert property (dec_storm_check |-> dec_valid && $past(frm_broadcast))
		else $error("storm check without broadcast");
	a_insert_untagged: assert property (dec_tag_insert |-> !$past(frm_tagged))
		else $error("insert on tagged frame");
	a_strip_tagged: assert property (dec_tag_strip |-> $past(frm_tagged))
		else $error("strip on untagged frame");
	a_queue_class: assert property (dec_queue != 2'h0 |-> dec_queue == dec_class_prio)
		else $error("queue differs from class");
	c_insert: cover property (dec_tag_insert);
	c_storm: cover property (dec_storm_check);
	c_queue_top: cover property (dec_queue == 2'h3);
endmodule

bind spf_fwd_ctrl spf_fwd_ctrl_checker u_chk (.mclk, .rst_b, .frm_valid, .frm_tagged,
	.frm_broadcast, .frm_dest_unknown, .dec_valid, .dec_class_prio, .dec_queue,
	.dec_unknown_mask, .dec_storm_check, .dec_tag_insert, .dec_tag_strip, .phy1_addr,
	.phy2_addr);

// ### verification/test_switch_port_forwarding_control.sv
`timescale 1ns/100ps
module test_switch_port_forwarding_control;
	// ************
	// Signals
	// ************
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, frm_pcp = 3'h0, dec_unknown_mask;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, dec_valid, dec_storm_check;
	logic [1:0] s_axi_bresp, s_axi_rresp, frm_rx_port = 2'h0, frm_tx_port = 2'h0;
	logic [1:0] frm_dscp_prio = 2'h0, dec_class_prio, dec_queue;
	logic frm_valid = 1'b0, frm_tagged = 1'b0, frm_ip = 1'b0, frm_dscp_hit = 1'b0;
	logic frm_broadcast = 1'b0, frm_dest_unknown = 1'b0, dec_tag_insert, dec_tag_strip;
	logic [4:0] phy1_addr, phy2_addr;
	int n_errors = 0, tests_run = 0, cyc = 0;

	spf_fwd_ctrl u_dut (
		.mclk(mclk),
		.rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.frm_valid(frm_valid),
		.frm_rx_port(frm_rx_port),
		.frm_tx_port(frm_tx_port),
		.frm_tagged(frm_tagged),
		.frm_pcp(frm_pcp),
		.frm_ip(frm_ip),
		.frm_dscp_hit(frm_dscp_hit),
		.frm_dscp_prio(frm_dscp_prio),
		.frm_broadcast(frm_broadcast),
		.frm_dest_unknown(frm_dest_unknown),
		.dec_valid(dec_valid),
		.dec_class_prio(dec_class_prio),
		.dec_queue(dec_queue),
		.dec_unknown_mask(dec_unknown_mask),
		.dec_storm_check(dec_storm_check),
		.dec_tag_insert(dec_tag_insert),
		.dec_tag_strip(dec_tag_strip),
		.phy1_addr(phy1_addr),
		.phy2_addr(phy2_addr)
	);

	always #20 mclk = ~mclk;

	// Whole run is under two hundred cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			$display("ERROR t=%0t timeout", $time);
			end_sim();
		end
	end

	// ************
	// Tasks
	// ************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
		@(posedge mclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
		@(posedge mclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h0, d});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// Frame: tp is tagged and tag priority, id is ip hit and its priority
	task automatic fr(input logic [1:0] rx, input logic [1:0] tx, input logic [3:0] tp,
			input logic [2:0] id, input logic [1:0] bu, input logic [9:0] e);
		@(posedge mclk);
		{frm_valid, frm_rx_port, frm_tx_port} <= {1'b1, rx, tx};
		{frm_tagged, frm_pcp, frm_ip, frm_dscp_hit, frm_dscp_prio} <= {tp, id[2], id};
		{frm_broadcast, frm_dest_unknown} <= bu;
		@(posedge mclk);
		frm_valid <= 1'b0;
		#1;
		chk({21'h0, dec_valid, dec_class_prio, dec_queue, dec_unknown_mask, dec_storm_check,
			dec_tag_insert, dec_tag_strip}, {21'h0, 1'b1, e});
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ************
	// Tests
	// ************
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(6'h0E, 8'h07, 2'h0);
		rd(6'h0F, 8'h08, 2'h0);
		rd(6'h0C, 8'h50, 2'h0);
		rd(6'h0D, 8'hFA, 2'h0);
		rd(6'h3F, 8'h00, 2'h2);
		wr(6'h3F, 8'h5A, 2'h2);
		chk({27'h0, phy1_addr}, 32'h1);
		chk({27'h0, phy2_addr}, 32'h2);
		$display("test reset done");
		wr(6'h0F, 8'hE8, 2'h0);
		wr(6'h0F, 8'hF7, 2'h0);
		wr(6'h0F, 8'hFF, 2'h0);
		wr(6'h0F, 8'h05, 2'h0);
		rd(6'h0F, 8'hE8, 2'h0);
		chk({27'h0, phy2_addr}, 32'h1E);
		wr(6'h0F, 8'h13, 2'h0);
		rd(6'h0F, 8'h10, 2'h0);
		// Lane 0 strobe low must leave the register untouched
		s_axi_wstrb <= 4'h0;
		wr(6'h0F, 8'hE8, 2'h0);
		s_axi_wstrb <= 4'h1;
		rd(6'h0F, 8'h10, 2'h0);
		$display("test transceiver done");
		fr(2'h1, 2'h2, 4'h0, 3'h0, 2'h1, 10'h000);
		wr(6'h0E, 8'h85, 2'h0);
		rd(6'h0E, 8'h85, 2'h0);
		fr(2'h1, 2'h2, 4'h0, 3'h0, 2'h1, 10'h028);
		fr(2'h1, 2'h2, 4'h0, 3'h0, 2'h0, 10'h000);
		$display("test unknown done");
		wr(6'h10, 8'h98, 2'h0);
		wr(6'h20, 8'h6F, 2'h0);
		wr(6'h30, 8'h20, 2'h0);
		rd(6'h10, 8'h98, 2'h0);
		rd(6'h20, 8'h6F, 2'h0);
		rd(6'h30, 8'h20, 2'h0);
		fr(2'h1, 2'h1, 4'h7, 3'h0, 2'h2, 10'h304);
		fr(2'h2, 2'h2, 4'hD, 3'h5, 2'h2, 10'h3C1);
		fr(2'h2, 2'h2, 4'h0, 3'h0, 2'h0, 10'h142);
		fr(2'h3, 2'h3, 4'hB, 3'h0, 2'h0, 10'h100);
		fr(2'h3, 2'h3, 4'h0, 3'h6, 2'h0, 10'h000);
		// Port code 0 selects no control register, only the global mask applies
		fr(2'h0, 2'h0, 4'hF, 3'h7, 2'h3, 10'h028);
		wr(6'h0C, 8'hC0, 2'h0);
		fr(2'h3, 2'h3, 4'hB, 3'h0, 2'h0, 10'h300);
		$display("test ports done");
		end_sim();
	end
endmodule
